// ### verilog/flash_dev.sv
// flash device end: decodes commands, runs self-timed program/erase
// assumes link pins asynchronous to mclk; they are synchronised here
`timescale 1ns/1ns
module flash_dev
#(
  parameter int PROG_CYC    = flash_seq_pkg::PROG_CYC,
  parameter int ERASE_CYC   = flash_seq_pkg::ERASE_CYC,
  parameter int ARRAY_CYC   = flash_seq_pkg::ARRAY_CYC,
  parameter int PDOWN_CYC   = flash_seq_pkg::PDOWN_CYC,
  parameter int RELEASE_CYC = flash_seq_pkg::RELEASE_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        quad_enable,
  input  wire logic [2:0]  block_protect_field,
  output logic             write_enable_latch,
  output logic             write_in_progress,
  output logic             deep_power_down,
  output logic             op_start,
  output logic [2:0]       op_kind,
  output logic [23:0]      op_addr,
  output logic             prog_valid,
  output logic [7:0]       prog_byte,
  output logic [7:0]       prog_offset,
  input  wire logic        prog_ready,
  flash_link_if.dev        link
);
  initial
  begin
    if (PROG_CYC < 1 || ERASE_CYC < 1 || ARRAY_CYC < 1 ||
        PDOWN_CYC < 1 || RELEASE_CYC < 1)
      $error("timing counts must be at least one");
  end
  typedef enum logic [1:0]
  {
    D_STANDBY = 2'h0,
    D_BUSY    = 2'h1,
    D_ENTER   = 2'h2,
    D_POWDN   = 2'h3
  } dstate_t;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic       sck_d_reg;
  logic       cs_d_reg;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg    <= 6'h3f;
      s2_reg    <= 6'h3f;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end
    else
    begin
      s1_reg    <= {link.cs_n, link.sck, link.io};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[4];
      cs_d_reg  <= s2_reg[5];
    end
  end
  logic cs_n_s;
  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  assign cs_n_s   = s2_reg[5];
  assign sck_rise = s2_reg[4] && !sck_d_reg && !cs_n_s;
  assign cs_rise  = cs_n_s && !cs_d_reg;
  assign cs_fall  = !cs_n_s && cs_d_reg;
  // ----------------------------------------
  // shifter: opcode and address single line, payload quad
  // ----------------------------------------
  logic [31:0] sh_reg;
  logic [8:0]  bitcnt_reg;
  logic [8:0]  nibcnt_reg;
  logic        quad_reg;
  logic [7:0]  offs_reg;
  logic        byte_ok;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_reg     <= 32'h0000_0000;
      bitcnt_reg <= 9'h000;
      nibcnt_reg <= 9'h000;
      quad_reg   <= 1'b0;
    end
    else if (cs_fall)
    begin
      bitcnt_reg <= 9'h000;
      nibcnt_reg <= 9'h000;
      quad_reg   <= 1'b0;
    end
    else if (sck_rise)
    begin
      if (quad_reg)
      begin
        sh_reg     <= {sh_reg[27:0], s2_reg[3:0]};
        nibcnt_reg <= nibcnt_reg + 9'h001;
      end
      else
      begin
        sh_reg     <= {sh_reg[30:0], s2_reg[0]};
        bitcnt_reg <= bitcnt_reg + 9'h001;
        // switch to four lines once a quad program opcode and address are in
        if (bitcnt_reg == 9'd31 && sh_reg[30:23] ==
            flash_seq_pkg::OP_QPROG)
          quad_reg <= 1'b1;
      end
    end
  end
  logic [7:0] opcode;
  logic [23:0] addr;
  logic addr_hold;
  logic [7:0] op_held_reg;
  logic [23:0] addr_held_reg;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_held_reg   <= 8'h00;
      addr_held_reg <= 24'h000000;
    end
    else if (sck_rise && !quad_reg)
    begin
      if (bitcnt_reg == 9'd7)
        op_held_reg <= {sh_reg[6:0], s2_reg[0]};
      if (bitcnt_reg == 9'd31)
        addr_held_reg <= {sh_reg[22:0], s2_reg[0]};
    end
  end
  assign opcode    = op_held_reg;
  assign addr      = addr_held_reg;
  assign addr_hold = (bitcnt_reg == 9'd32);
  // quad byte done on second nibble
  assign byte_ok = sck_rise && quad_reg && nibcnt_reg[0];
  // ----------------------------------------
  // two-entry payload buffer toward array port
  // ----------------------------------------
  logic [15:0] buf_reg;
  logic [15:0] boff_reg;
  logic [1:0]  cnt_reg;
  logic        wr_reg;
  logic        push;
  logic        pop;
  assign push = byte_ok && (cnt_reg != 2'd2);
  assign pop  = prog_valid && prog_ready;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_reg  <= 16'h0000;
      boff_reg <= 16'h0000;
      cnt_reg  <= 2'd0;
      wr_reg   <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        buf_reg[7:0]  <= buf_reg[15:8];
        boff_reg[7:0] <= boff_reg[15:8];
      end
      if (push)
      begin
        if (cnt_reg == 2'd0 || (cnt_reg == 2'd1 && pop))
        begin
          buf_reg[7:0]  <= {sh_reg[3:0], s2_reg[3:0]};
          boff_reg[7:0] <= offs_reg;
        end
        else
        begin
          buf_reg[15:8]  <= {sh_reg[3:0], s2_reg[3:0]};
          boff_reg[15:8] <= offs_reg;
        end
      end
      cnt_reg <= cnt_reg + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);
      // a full buffer drops a byte; flagged so program aborts, but only if no pop in that cycle
      if (cs_fall)
        wr_reg <= 1'b0;
      else if (byte_ok && cnt_reg == 2'd2 && !pop)
        wr_reg <= 1'b1;
    end
  end
  // page offset wraps at the page end
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      offs_reg <= 8'h00;
    else if (sck_rise && !quad_reg && bitcnt_reg == 9'd31)
      offs_reg <= {sh_reg[6:0], s2_reg[0]};
    else if (byte_ok)
      offs_reg <= offs_reg + 8'h01;
  end
  assign prog_valid  = (cnt_reg != 2'd0);
  assign prog_byte   = buf_reg[7:0];
  assign prog_offset = boff_reg[7:0];
  // ----------------------------------------
  // command decode at select rise
  // ----------------------------------------
  function automatic logic bp_hit(input logic [2:0] bp,
                                  input logic [7:0] region);
    logic [7:0] lim;
    lim = 8'h00;
    // field covers the top 2^(bp-1) regions, all at 7
    if (bp != 3'h0)
      lim = 8'(8'h40 >> (3'h7 - bp));
    bp_hit = (bp == 3'h7) || (bp != 3'h0 && region >= 8'(8'h80 - lim));
  endfunction
  dstate_t     st_reg;
  logic [31:0] tmr_reg;
  logic        wel_reg;
  logic        start_reg;
  logic [2:0]  kind_reg;
  logic [23:0] oaddr_reg;
  logic        bytes_any;
  logic        param_ok;
  logic        prot;
  assign bytes_any = (nibcnt_reg >= 9'd2) && !nibcnt_reg[0];
  assign param_ok  = (addr[23:16] == flash_seq_pkg::PARAM_REGION);
  assign prot      = bp_hit(block_protect_field, addr[23:16]);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg    <= D_STANDBY;
      tmr_reg   <= 32'h0;
      wel_reg   <= 1'b0;
      start_reg <= 1'b0;
      kind_reg  <= 3'h0;
      oaddr_reg <= 24'h000000;
    end
    else
    begin
      start_reg <= 1'b0;
      unique case (st_reg)
        D_STANDBY:
        begin
          if (cs_rise && bitcnt_reg == 9'd8)
          begin
            if (opcode == flash_seq_pkg::OP_WRITE_ENABLE_CMD)
              wel_reg <= 1'b1;
            else if (opcode == flash_seq_pkg::OP_PDOWN)
            begin
              st_reg  <= D_ENTER;
              tmr_reg <= 32'(PDOWN_CYC);
            end
            else if (opcode == flash_seq_pkg::OP_ARRAY && wel_reg &&
                     block_protect_field == 3'h0)
            begin
              st_reg    <= D_BUSY;
              tmr_reg   <= 32'(ARRAY_CYC);
              start_reg <= 1'b1;
              kind_reg  <= flash_seq_pkg::CMD_ARRAY;
              oaddr_reg <= 24'h000000;
            end
          end
          else if (cs_rise && addr_hold && !quad_reg && wel_reg &&
                   !prot)
          begin
            if (opcode == flash_seq_pkg::OP_S64K)
            begin
              st_reg    <= D_BUSY;
              tmr_reg   <= 32'(ERASE_CYC);
              start_reg <= 1'b1;
              kind_reg  <= flash_seq_pkg::CMD_S64K;
              oaddr_reg <= {addr[23:16], 16'h0000};
            end
            else if ((opcode == flash_seq_pkg::OP_P4K ||
                      opcode == flash_seq_pkg::OP_P8K) && param_ok)
            begin
              st_reg    <= D_BUSY;
              tmr_reg   <= 32'(ERASE_CYC);
              start_reg <= 1'b1;
              kind_reg  <= (opcode == flash_seq_pkg::OP_P8K) ?
                           flash_seq_pkg::CMD_P8K : flash_seq_pkg::CMD_P4K;
              oaddr_reg <= (opcode == flash_seq_pkg::OP_P8K) ?
                           {addr[23:13], 13'h0000}
                         : {addr[23:12], 12'h000};
            end
          end
          else if (cs_rise && quad_reg && bytes_any && wel_reg &&
                   quad_enable && !wr_reg &&
                   !bp_hit(block_protect_field, addr[23:16]))
          begin
            st_reg    <= D_BUSY;
            tmr_reg   <= 32'(PROG_CYC);
            start_reg <= 1'b1;
            kind_reg  <= flash_seq_pkg::CMD_QPROG;
            oaddr_reg <= addr;
          end
        end
        D_BUSY:
        begin
          // busy: other commands ignored
          tmr_reg <= tmr_reg - 32'h1;
          if (tmr_reg == 32'h2)
            wel_reg <= 1'b0;
          if (tmr_reg == 32'h1)
            st_reg <= D_STANDBY;
        end
        D_ENTER:
        begin
          tmr_reg <= tmr_reg - 32'h1;
          if (tmr_reg == 32'h1)
            st_reg <= D_POWDN;
        end
        D_POWDN:
        begin
          if (cs_rise && bitcnt_reg >= 9'd8 &&
              opcode == flash_seq_pkg::OP_RELEASE)
          begin
            st_reg  <= D_ENTER;
            tmr_reg <= 32'(RELEASE_CYC);
            kind_reg <= flash_seq_pkg::CMD_RELEASE;
          end
        end
      endcase
      if (st_reg == D_ENTER && tmr_reg == 32'h1 &&
          kind_reg == flash_seq_pkg::CMD_RELEASE)
      begin
        st_reg   <= D_STANDBY;
        kind_reg <= 3'h0;
      end
    end
  end
  assign write_enable_latch = wel_reg;
  assign write_in_progress  = (st_reg == D_BUSY);
  assign deep_power_down    = (st_reg == D_POWDN);
  assign op_start           = start_reg;
  assign op_kind            = kind_reg;
  assign op_addr            = oaddr_reg;
  assign link.io_dev_out    = 4'h0;
  assign link.io_dev_oe     = 4'h0;
endmodule

// ### verilog/flash_seq_pkg.sv
// constants and encodings for the flash sequencer pair
// assumes one clock mclk at 125 MHz shared by both ends
//
// What this block does
// - quad page program needs quad enable set
// - host sends 32h, 24-bit address, data bytes
// - quad data on four lines, any byte count but a multiple of 256
// - quad page program needs write enable latch
// - param erase: opcode, address, sector from A23-A12
// - param erase outside parameter region ignored
// - 8k erase ignores A12, erases pair
// - 64k and param erase run only if select rises after bit 32
// - busy flag while self-timed op; latch cleared
// - protected sector erase not executed
// - 64k erase covers region; small erase not
// - array erase needs rise after 8th bit
// - array erase only with protect field zero
// - power-down after 8th bit, delay after rise
// - in power-down only release is obeyed
// - power-down rejected while operation busy
// - reset always yields standby
// - erase requires prior write enable
// - host holds select low through sequence
// - standby when select high and idle
// - page data wraps, last 256 bytes kept
// - release leaves power-down after delay
package flash_seq_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_QPROG  = 8'h32;
  localparam logic [7:0] OP_P4K    = 8'h20;
  localparam logic [7:0] OP_P8K    = 8'h40;
  localparam logic [7:0] OP_S64K   = 8'hd8;
  localparam logic [7:0] OP_ARRAY  = 8'hc7;
  localparam logic [7:0] OP_PDOWN  = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam int CLK_MHZ = 125;
  // microseconds, shortened
  localparam int PROG_US    = 8;
  localparam int ERASE_US   = 16;
  localparam int ARRAY_US   = 32;
  localparam int PDOWN_US   = 3;
  localparam int RELEASE_US = 3;
  localparam int PROG_CYC    = PROG_US * CLK_MHZ;
  localparam int ERASE_CYC   = ERASE_US * CLK_MHZ;
  localparam int ARRAY_CYC   = ARRAY_US * CLK_MHZ;
  localparam int PDOWN_CYC   = PDOWN_US * CLK_MHZ;
  localparam int RELEASE_CYC = RELEASE_US * CLK_MHZ;
  // parameter sectors: region 0
  localparam logic [7:0] PARAM_REGION = 8'h00;
  localparam int PAGE_BYTES = 256;
  localparam int SCK_DIV    = 4;
  typedef enum logic [2:0]
  {
    CMD_WRITE_ENABLE_CMD    = 3'h0,
    CMD_QPROG   = 3'h1,
    CMD_P4K     = 3'h2,
    CMD_P8K     = 3'h3,
    CMD_S64K    = 3'h4,
    CMD_ARRAY   = 3'h5,
    CMD_PDOWN   = 3'h6,
    CMD_RELEASE = 3'h7
  } cmd_t;
  function automatic logic [7:0] cmd_opcode(input cmd_t c);
    unique case (c)
      CMD_WRITE_ENABLE_CMD:    cmd_opcode = OP_WRITE_ENABLE_CMD;
      CMD_QPROG:   cmd_opcode = OP_QPROG;
      CMD_P4K:     cmd_opcode = OP_P4K;
      CMD_P8K:     cmd_opcode = OP_P8K;
      CMD_S64K:    cmd_opcode = OP_S64K;
      CMD_ARRAY:   cmd_opcode = OP_ARRAY;
      CMD_PDOWN:   cmd_opcode = OP_PDOWN;
      CMD_RELEASE: cmd_opcode = OP_RELEASE;
    endcase
  endfunction
endpackage

// ### verilog/flash_link_if.sv
// serial link between host controller and flash device
// assumes both ends clocked by the same mclk
`timescale 1ns/1ns
interface flash_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] io_host_out;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev_out;
  logic [3:0] io_dev_oe;
  logic [3:0] io;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (io_host_oe[i])
        io[i] = io_host_out[i];
      else if (io_dev_oe[i])
        io[i] = io_dev_out[i];
      else
        io[i] = 1'b1;
    end
  end
  modport host (output cs_n, output sck, output io_host_out,
                output io_host_oe, input io);
  modport dev (input cs_n, input sck, output io_dev_out,
               output io_dev_oe, input io);
endinterface

// ### verilog/flash_host.sv
// host controller end: sends one command per request over the link
// assumes requests from logic on mclk; link shares mclk
`timescale 1ns/1ns
module flash_host
#(
  parameter int DIV = flash_seq_pkg::SCK_DIV
)
(
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 req_valid,
  input  wire flash_seq_pkg::cmd_t  req_cmd,
  input  wire logic [23:0]          req_addr,
  output logic                      req_ready,
  input  wire logic                 data_valid,
  input  wire logic [7:0]           data_byte,
  input  wire logic                 data_last,
  output logic                      data_ready,
  output logic                      done,
  flash_link_if.host                link
);
  initial
  begin
    if (DIV < 2)
      $error("sck divider too small");
  end
  typedef enum logic [2:0]
  {
    H_IDLE = 3'h0,
    H_OP   = 3'h1,
    H_ADDR = 3'h2,
    H_DATA = 3'h3,
    H_END  = 3'h4
  } hstate_t;
  hstate_t     state_reg;
  logic [7:0]  div_reg;
  logic        sck_reg;
  logic        cs_n_reg;
  logic [31:0] shift_reg;
  logic [5:0]  bits_reg;
  logic        quad_reg;
  logic        last_reg;
  logic        ready_reg;
  logic        done_reg;
  logic        has_addr;
  logic        tick;
  assign tick = (div_reg == 8'(DIV - 1));
  assign has_addr = (req_cmd != flash_seq_pkg::CMD_WRITE_ENABLE_CMD) &&
                    (req_cmd != flash_seq_pkg::CMD_ARRAY) &&
                    (req_cmd != flash_seq_pkg::CMD_PDOWN) &&
                    (req_cmd != flash_seq_pkg::CMD_RELEASE);
  // ----------------------------------------
  // sck divider: data set on low half, sampled on rise
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      div_reg <= 8'h00;
    else if (state_reg == H_IDLE || tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end
  // ----------------------------------------
  // sequence; select held low until last bit out
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= H_IDLE;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      shift_reg <= 32'h0000_0000;
      bits_reg  <= 6'h00;
      quad_reg  <= 1'b0;
      last_reg  <= 1'b0;
      ready_reg <= 1'b1;
      done_reg  <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE:
        begin
          if (req_valid && ready_reg)
          begin
            ready_reg <= 1'b0;
            cs_n_reg  <= 1'b0;
            quad_reg  <= 1'b0;
            shift_reg <= {flash_seq_pkg::cmd_opcode(req_cmd), req_addr};
            bits_reg  <= has_addr ? 6'd32 : 6'd8;
            last_reg  <= (req_cmd != flash_seq_pkg::CMD_QPROG);
            state_reg <= H_OP;
          end
        end
        H_OP, H_DATA:
        begin
          if (tick)
          begin
            sck_reg <= ~sck_reg;
            if (sck_reg)
            begin
              shift_reg <= quad_reg ? {shift_reg[27:0], 4'h0}
                                    : {shift_reg[30:0], 1'b0};
              bits_reg  <= bits_reg - (quad_reg ? 6'd4 : 6'd1);
              if (bits_reg == (quad_reg ? 6'd4 : 6'd1))
                state_reg <= last_reg ? H_END : H_ADDR;
            end
          end
        end
        H_ADDR:
        begin
          // quad payload: load next byte, stall on empty source
          if (data_valid)
          begin
            shift_reg <= {data_byte, 24'h000000};
            bits_reg  <= 6'd8;
            quad_reg  <= 1'b1;
            last_reg  <= data_last;
            state_reg <= H_DATA;
          end
        end
        H_END:
        begin
          if (tick)
          begin
            cs_n_reg  <= 1'b1;
            ready_reg <= 1'b1;
            done_reg  <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default:
          state_reg <= H_IDLE;
      endcase
    end
  end
  assign req_ready   = ready_reg;
  assign data_ready  = (state_reg == H_ADDR);
  assign done        = done_reg;
  assign link.cs_n   = cs_n_reg;
  assign link.sck    = sck_reg;
  assign link.io_host_out = quad_reg ? shift_reg[31:28]
                                     : {3'b000, shift_reg[31]};
  assign link.io_host_oe  = cs_n_reg ? 4'h0 : (quad_reg ? 4'hf : 4'h1);
endmodule

// ### verification/flash_link_assertions.sv
// checker for the serial link joining the host and device ends
// assumes one clock mclk; inputs are link signals
`timescale 1ns/1ns
module flash_link_assertions
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] io_host_out,
  input wire logic [3:0] io_host_oe,
  input wire logic [3:0] io_dev_out,
  input wire logic [3:0] io_dev_oe,
  input wire logic [3:0] io
);
  logic       sck_reg;
  logic [9:0] bits_reg;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // sck rises in this frame
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      {sck_reg, bits_reg} <= 11'h000;
    else
    begin
      sck_reg <= sck;
      if (cs_n)
        bits_reg <= 10'h000;
      else if (sck && !sck_reg)
        bits_reg <= bits_reg + 10'h001;
    end
  end
  // --------------------------------------------------------------
  // link properties
  // --------------------------------------------------------------
  a_dev_no_drive: assert property (io_dev_oe == 4'h0)
    else $error("device drove the data lines");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_frame_min_len: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select released too soon after frame start");
  a_sck_high_len: assert property ($rose(sck) |-> sck [*4])
    else $error("serial clock high phase too short");
  a_io_hold_high: assert property ((sck && sck_reg) |-> $stable(io_host_out))
    else $error("data changed while serial clock high");
  a_frame_bit_count: assert property ($rose(cs_n) |-> (bits_reg == 10'h008
    || bits_reg == 10'h020 || (bits_reg > 10'h020 && !bits_reg[0])))
    else $error("frame closed after a wrong number of bits");
  a_quad_after_addr: assert property (io_host_oe == 4'hf |-> bits_reg >= 10'h020)
    else $error("four-line data before the address ended");
  a_oe_shape: assert property (io_host_oe inside {4'h0, 4'h1, 4'hf})
    else $error("host enabled an unexpected set of lines");
endmodule

// ### verification/spi_flash_program_erase_powerdown_tb_top.sv
// self-checking bench: host end drives device end over the link
// assumes the package and link interface are compiled beforehand
`timescale 1ns/1ns
module spi_flash_program_erase_powerdown_tb_top;
  logic                mclk = 1'b0;
  logic                rstn = 1'b0;
  logic                req_valid = 1'b0;
  flash_seq_pkg::cmd_t req_cmd = flash_seq_pkg::CMD_WRITE_ENABLE_CMD;
  logic [23:0]         req_addr = 24'h000000;
  logic                data_valid = 1'b0;
  logic [7:0]          data_byte = 8'h00;
  logic                data_last = 1'b0;
  logic                quad_enable = 1'b0;
  logic [2:0]          block_protect_field = 3'h0;
  logic                prog_ready = 1'b0;
  logic                req_ready, data_ready, done, prog_valid, op_start;
  logic                write_enable_latch, write_in_progress;
  logic                deep_power_down;
  logic [2:0]          op_kind, kind_seen;
  logic [23:0]         op_addr;
  logic [7:0]          prog_byte, prog_offset;
  logic [7:0]          exp_b[$], got_b[$], got_o[$];
  logic [31:0]         lfsr_reg = 32'h00010316;
  logic [31:0]         stall_reg = 32'h00010316;
  int                  error_cnt = 0;
  int                  compares = 0;
  int                  starts = 0;
  int                  s;
  logic [2:0]          t_cmd[11] = '{2, 2, 2, 3, 3, 4, 4, 4, 2, 5, 5};
  logic [7:0]          t_hi[11] = '{0, 0, 1, 0, 5, 0, 8'h7f, 8'h7e, 0, 0, 0};
  logic [2:0]          t_bp[11] = '{0, 0, 0, 0, 0, 0, 1, 1, 7, 2, 0};
  always #4 mclk = ~mclk;
  flash_link_if flash_link_if_i ();
  flash_host flash_host_i (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_ready(req_ready),
    .data_valid(data_valid), .data_byte(data_byte), .data_last(data_last),
    .data_ready(data_ready), .done(done), .link(flash_link_if_i));
  flash_dev #(.PROG_CYC(40), .ERASE_CYC(60), .ARRAY_CYC(300),
    .PDOWN_CYC(20), .RELEASE_CYC(20)) flash_dev_i (.mclk(mclk),
    .rstn(rstn), .quad_enable(quad_enable),
    .block_protect_field(block_protect_field),
    .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress),
    .deep_power_down(deep_power_down), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .prog_valid(prog_valid),
    .prog_byte(prog_byte), .prog_offset(prog_offset),
    .prog_ready(prog_ready), .link(flash_link_if_i));
  flash_link_assertions flash_link_assertions_i (.mclk(mclk), .rstn(rstn),
    .cs_n(flash_link_if_i.cs_n), .sck(flash_link_if_i.sck),
    .io_host_out(flash_link_if_i.io_host_out),
    .io_host_oe(flash_link_if_i.io_host_oe),
    .io_dev_out(flash_link_if_i.io_dev_out),
    .io_dev_oe(flash_link_if_i.io_dev_oe), .io(flash_link_if_i.io));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // protection covers the top 2^(bp-1) of 128 regions, all at 7
  function automatic bit runs(input logic [2:0] c, input logic [23:0] a,
                              input logic [2:0] p);
    int r;
    r = a[22:16];
    runs = !(p == 3'h7 || (p != 3'h0 && r >= 128 - (1 << (p - 3'h1))));
    if (c == 3'h2 || c == 3'h3)
      runs = runs && a[23:16] == 8'h00;
    if (c == 3'h5)
      runs = p == 3'h0;
  endfunction
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input logic [2:0] c, input logic [23:0] a, input int n);
    int k = 0;
    @(negedge mclk);
    req_valid = 1'b1;
    req_cmd = flash_seq_pkg::cmd_t'(c);
    req_addr = a;
    while (req_ready !== 1'b1 && k < 100)
    begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      lfsr_reg = lfsr(lfsr_reg);
      data_valid = 1'b1;
      data_byte = lfsr_reg[7:0];
      data_last = i == n - 1;
      exp_b.push_back(lfsr_reg[7:0]);
      while (data_ready !== 1'b1 && k < 2000)
      begin
        @(negedge mclk);
        k++;
      end
      @(negedge mclk);
    end
    data_valid = 1'b0;
    data_last = 1'b0;
    while (done !== 1'b1 && k < 3000)
    begin
      @(negedge mclk);
      k++;
    end
    chk("done", 24'h1, {23'h0, done});
    repeat (8) @(negedge mclk);
  endtask
  task automatic wait_lvl(input bit pd, input logic v);
    for (int k = 0; k < 400 && (pd ? deep_power_down : write_in_progress)
         !== v; k++)
      @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge mclk)
  begin
    stall_reg = lfsr(stall_reg);
    prog_ready = stall_reg[0];
  end
  always @(posedge mclk)
  begin
    if (op_start === 1'b1)
    begin
      starts++;
      kind_seen = op_kind;
    end
    if (prog_valid === 1'b1 && prog_ready === 1'b1)
    begin
      got_b.push_back(prog_byte);
      got_o.push_back(prog_offset);
    end
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    $display("wrong value watchdog expected finish seen timeout");
    summarize;
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      lfsr_reg = lfsr(lfsr_reg);
      block_protect_field = t_bp[i];
      if (i > 0)
        send(3'h0, 24'h0, 0);
      chk("latch", {23'h0, i > 0}, {23'h0, write_enable_latch});
      s = starts;
      send(t_cmd[i], {t_hi[i], lfsr_reg[15:0]}, 0);
      chk("start", {23'h0, i > 0 && runs(t_cmd[i], {t_hi[i], 16'h0},
        t_bp[i])}, 24'(starts - s));
      if (starts != s)
      begin
        chk("kind", {21'h0, t_cmd[i]}, {21'h0, kind_seen});
        chk("busy", 24'h1, {23'h0, write_in_progress});
        wait_lvl(0, 1'b0);
        chk("latch after", 24'h0, {23'h0, write_enable_latch});
      end
    end
    $display("test erase table done");
    block_protect_field = 3'h0;
    quad_enable = 1'b1;
    s = starts;
    send(3'h1, 24'h0000fd, 2);
    chk("start no latch", 24'h0, 24'(starts - s));
    quad_enable = 1'b0;
    send(3'h0, 24'h0, 0);
    send(3'h1, 24'h0000fd, 2);
    chk("start quad off", 24'h0, 24'(starts - s));
    quad_enable = 1'b1;
    exp_b.delete();
    got_b.delete();
    got_o.delete();
    send(3'h1, {8'h00, lfsr_reg[7:0], 8'hfd}, 5);
    wait_lvl(0, 1'b0);
    chk("start quad", 24'h1, 24'(starts - s));
    chk("bytes", 24'h5, 24'(got_b.size()));
    for (int i = 0; i < 5; i++)
    begin
      chk("byte", {16'h0, exp_b[i]}, {16'h0, got_b[i]});
      chk("offset", {16'h0, 8'hfd + 8'(i)}, {16'h0, got_o[i]});
    end
    $display("test quad program done");
    send(3'h6, 24'h0, 0);
    wait_lvl(1, 1'b1);
    chk("power down", 24'h1, {23'h0, deep_power_down});
    send(3'h0, 24'h0, 0);
    chk("latch in power down", 24'h0, {23'h0, write_enable_latch});
    send(3'h7, 24'h0, 0);
    wait_lvl(1, 1'b0);
    chk("released", 24'h0, {23'h0, deep_power_down});
    send(3'h0, 24'h0, 0);
    send(3'h5, 24'h0, 0);
    send(3'h6, 24'h0, 0);
    chk("busy kept", 24'h1, {23'h0, write_in_progress});
    wait_lvl(0, 1'b0);
    repeat (40) @(negedge mclk);
    chk("power down refused", 24'h0, {23'h0, deep_power_down});
    $display("test power down done");
    send(3'h6, 24'h0, 0);
    wait_lvl(1, 1'b1);
    send(3'h0, 24'h0, 0);
    rstn = 1'b0;
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    chk("standby after reset", 24'h0, {21'h0, deep_power_down,
      write_enable_latch, write_in_progress});
    $display("test reset done");
    summarize;
  end
endmodule
